// [bench/ddrbs_core_tb.sv]
// Self-checking bench for the burst-of-two SRAM core
`timescale 1ns/1ps
module ddrbs_core_tb;
  localparam int AW = 6;
  localparam int DW = 36;
  localparam int L = ddrbs_pkg::LANE_W;
  localparam int B = DW / L;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic k_run = 1'b1;
  logic sys_rst = 1'b1;
  logic dll_on = 1'b0;
  logic [3:0] imp_tgt = 4'h0;
  logic term_ctrl = 1'b1;
  logic term_opt = 1'b0;
  logic load_address_n, rw_sel, dq_oe_n, term_clk_en, term_bw_en, cal_done, dev_ready;
  logic [AW-1:0] addr;
  logic [B-1:0] bw0_n, bw1_n;
  logic [DW-1:0] din0, din1, dout0, dout1;
  logic [1:0] ind, tde;
  logic [3:0] imp_code;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 35676;
  int cyc = 0;
  int k;
  logic [DW-1:0] exp_mem [int];
  logic [2*DW-1:0] exp_q[$];

  always #2.5 clk_sys = ~clk_sys;
  // Odd start offset keeps the link edges off the system grid
  initial begin
    #1.3;
    forever #40 if (k_run) clk_link = ~clk_link;
  end

  ddrbs_core #(.ADDR_W(AW), .DATA_W(DW), .STOP_CYC(12)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
    .load_address_n(load_address_n), .rw_sel(rw_sel), .addr(addr),
    .byte_write_strobe_n_b0(bw0_n), .byte_write_strobe_n_b1(bw1_n),
    .dq_in_b0(din0), .dq_in_b1(din1), .dq_out_b0(dout0), .dq_out_b1(dout1),
    .dq_oe_n(dq_oe_n), .read_valid_indicator(ind), .echo_clock_true(),
    .echo_clock_complement(), .dll_on(dll_on), .impedance_target(imp_tgt),
    .imp_code(imp_code), .cal_done(cal_done), .dev_ready(dev_ready),
    .input_termination_ctrl(term_ctrl), .term_option(term_opt),
    .term_clk_en(term_clk_en), .term_data_en(tde), .term_bw_en(term_bw_en));

  ddrbs_ctrl_model #(.ADDR_W(AW), .DATA_W(DW)) ctrl_u (
    .clk_link(clk_link), .load_address_n(load_address_n), .rw_sel(rw_sel),
    .addr(addr), .byte_write_strobe_n_b0(bw0_n), .byte_write_strobe_n_b1(bw1_n),
    .dq_in_b0(din0), .dq_in_b1(din1), .dq_out_b0(dout0), .dq_out_b1(dout1),
    .dq_oe_n(dq_oe_n));

  // ----------------------------------------
  // Helpers and reference model
  // ----------------------------------------
  task automatic check(input string what, input logic [2*DW-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic sys(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : sys

  function automatic logic [DW-1:0] rnd();
    return DW'({$random(seed), $random(seed)});
  endfunction : rnd

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, d, input logic [B-1:0] s);
    for (int l = 0; l < B; l++) if (!s[l]) o[l*L+:L] = d[l*L+:L];
    return o;
  endfunction : merge

  task automatic wr(input logic [AW-1:0] a, input logic [B-1:0] s0, s1,
                    input logic [DW-1:0] d0, d1);
    exp_mem[int'(a)*2] = merge(exp_mem[int'(a)*2], d0, s0);
    exp_mem[int'(a)*2+1] = merge(exp_mem[int'(a)*2+1], d1, s1);
    ctrl_u.push_cmd(1'b0, a, s0, s1, d0, d1);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    exp_q.push_back({exp_mem[int'(a)*2], exp_mem[int'(a)*2+1]});
    ctrl_u.push_cmd(1'b1, a, '1, '1, '0, '0);
  endtask : rd

  task automatic flush(input int rl);
    int w;
    for (w = 0; w < 600 && (ctrl_u.cmd_q.size() > 0 || ctrl_u.rd_q.size() < exp_q.size());
         w++) @(posedge clk_link);
    repeat (4) @(posedge clk_link);
    check("read count", 72'(ctrl_u.rd_q.size()), 72'(exp_q.size()));
    while (exp_q.size() > 0 && ctrl_u.rd_q.size() > 0) begin
      check("read data", ctrl_u.rd_q.pop_front(), exp_q.pop_front());
      check("read latency", 72'(ctrl_u.lat_q.pop_front()), 72'(rl));
    end
    exp_q.delete();
  endtask : flush

  task automatic traffic(input int n, input int rl);
    int j;
    wr(3'h3, 4'h5, 4'ha, rnd(), rnd());
    rd(3'h3);
    wr(3'h2, 4'hf, 4'hf, rnd(), rnd());
    rd(3'h2);
    rd(3'h4);
    wr(3'h4, 4'h0, 4'h3, rnd(), rnd());
    rd(3'h4);
    for (j = 0; j < n; j++) begin
      if (($random(seed) & 1) == 0) wr(AW'($random(seed) & 7), B'($random(seed)),
                                       B'($random(seed)), rnd(), rnd());
      else rd(AW'($random(seed) & 7));
    end
    flush(rl);
  endtask : traffic

  task automatic walk(input int rl);
    int j;
    logic [4:0] e;
    @(negedge clk_link);
    rd(3'h1);
    for (j = -1; j < 5; j++) begin
      @(negedge clk_link);
      e = (j == rl - 1) ? 5'h19 : (j == rl) ? 5'h04 : (j == rl + 1) ? 5'h12 : 5'h13;
      check("read slots", {dq_oe_n, ind, tde}, e);
    end
    flush(rl);
  endtask : walk

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    @(posedge clk_sys) imp_tgt <= 4'($random(seed));
    sys(60);
    @(posedge clk_sys) sys_rst <= 1'b0;
    sys(3);
    check("impedance start", imp_code, 4'h8);
    sys(1015);
    check("cal early", cal_done, 1'b0);
    sys(10);
    check("cal final", {cal_done, imp_code}, {1'b1, imp_tgt});
    check("ready bypass", dev_ready, 1'b1);
    for (k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      term_ctrl <= k[1];
      term_opt <= k[0];
      sys(2);
      check("termination", {term_clk_en, term_bw_en, tde},
            {k[1] & ~k[0], k[1], k[1], k[1]});
    end
    @(posedge clk_sys) term_ctrl <= 1'b1;
    repeat (6) @(posedge clk_link);
    for (k = 0; k < 8; k++) wr(AW'(k), 4'h0, 4'h0, rnd(), rnd());
    traffic(40, ddrbs_pkg::RL_BYP);
    walk(ddrbs_pkg::RL_BYP);
    @(posedge clk_sys) dll_on <= 1'b1;
    sys(20);
    check("ready drop", dev_ready, 1'b0);
    for (k = 0; k < 2200 && dev_ready !== 1'b1; k++) @(posedge clk_link);
    check("lock edges", (k >= 2044 && k <= 2052), 1'b1);
    repeat (6) @(posedge clk_link);
    traffic(40, ddrbs_pkg::RL_DLL);
    walk(ddrbs_pkg::RL_DLL);
    k_run = 1'b0;
    sys(60);
    check("stopped clock", dev_ready, 1'b0);
    k_run = 1'b1;
    repeat (100) @(posedge clk_link);
    check("no early lock", dev_ready, 1'b0);
    print_verdict();
  end
endmodule : ddrbs_core_tb

// [bench/ddrbs_ctrl_model.sv]
// Memory controller model driving the link side of the SRAM core
`timescale 1ns/1ps
module ddrbs_ctrl_model #(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 36,
  localparam int B = DATA_W / ddrbs_pkg::LANE_W
) (
  input  wire logic              clk_link,
  output logic                   load_address_n,
  output logic                   rw_sel,
  output logic [ADDR_W-1:0]      addr,
  output logic [B-1:0]           byte_write_strobe_n_b0,
  output logic [B-1:0]           byte_write_strobe_n_b1,
  output logic [DATA_W-1:0]      dq_in_b0,
  output logic [DATA_W-1:0]      dq_in_b1,
  input  wire logic [DATA_W-1:0] dq_out_b0,
  input  wire logic [DATA_W-1:0] dq_out_b1,
  input  wire logic              dq_oe_n
);
  localparam int DO  = 2 * DATA_W;
  localparam int TOP = DO + 2 * B + ADDR_W;
  logic [TOP:0]        cmd_q[$];
  logic [TOP:0]        c;
  logic [TOP:0]        hold;
  logic [2*DATA_W-1:0] rd_q[$];
  int                  lat_q[$];
  int                  iss_q[$];
  int                  edge_n = 0;
  int                  last_rd = -100;
  logic                due = 1'b0;
  logic                go;

  task automatic push_cmd(input logic rd, input logic [ADDR_W-1:0] a,
                          input logic [B-1:0] s0, s1, input logic [DATA_W-1:0] d0, d1);
    cmd_q.push_back({rd, a, s0, s1, d0, d1});
  endtask : push_cmd

  initial begin
    load_address_n = 1'b1;
    rw_sel = 1'b0;
    addr = '0;
    byte_write_strobe_n_b0 = '1;
    byte_write_strobe_n_b1 = '1;
    dq_in_b0 = '0;
    dq_in_b1 = '0;
  end

  // ----------------------------------------
  // Command issue and late write data
  // ----------------------------------------
  always @(posedge clk_link) begin
    edge_n = edge_n + 1;
    // Idle data lines toggle so stale values are never mistaken for data
    dq_in_b0 <= due ? hold[DO-1:DATA_W] : ~dq_in_b0;
    dq_in_b1 <= due ? hold[DATA_W-1:0] : ~dq_in_b1;
    byte_write_strobe_n_b0 <= due ? hold[DO+B+:B] : '1;
    byte_write_strobe_n_b1 <= due ? hold[DO+:B] : '1;
    // A write waits until the bus has turned round after the last read
    go = cmd_q.size() > 0 && (cmd_q[0][TOP] || edge_n >= last_rd + 4);
    if (go) c = cmd_q.pop_front();
    load_address_n <= !go;
    rw_sel <= go ? c[TOP] : ~rw_sel;
    addr <= go ? c[DO+2*B+:ADDR_W] : ~addr;
    if (go && c[TOP]) begin
      last_rd = edge_n;
      iss_q.push_back(edge_n + 1);
    end
    due = go && !c[TOP];
    if (due) hold = c;
  end

  always @(negedge clk_link) begin
    if (dq_oe_n === 1'b0 && iss_q.size() > 0) begin
      rd_q.push_back({dq_out_b0, dq_out_b1});
      lat_q.push_back(edge_n - iss_q.pop_front());
    end
  end
endmodule : ddrbs_ctrl_model

// [src/ddrbs_core.sv]
// Burst-of-two common-I/O SRAM device core with write buffers and termination
`timescale 1ns/1ps
module ddrbs_core #(
  parameter int ADDR_W   = ddrbs_pkg::ADDR_W,
  parameter int DATA_W   = ddrbs_pkg::DATA_W,
  parameter int STOP_CYC = ddrbs_pkg::CLK_STOP_CYC
) (
  input  wire logic                            clk_sys,
  input  wire logic                            sys_rst,
  input  wire logic                            clk_link,
  input  wire logic                            load_address_n,
  input  wire logic                            rw_sel,
  input  wire logic [ADDR_W-1:0]               addr,
  input  wire logic [DATA_W/ddrbs_pkg::LANE_W-1:0] byte_write_strobe_n_b0,
  input  wire logic [DATA_W/ddrbs_pkg::LANE_W-1:0] byte_write_strobe_n_b1,
  input  wire logic [DATA_W-1:0]               dq_in_b0,
  input  wire logic [DATA_W-1:0]               dq_in_b1,
  output logic [DATA_W-1:0]                    dq_out_b0,
  output logic [DATA_W-1:0]                    dq_out_b1,
  output logic                                 dq_oe_n,
  output logic [1:0]                           read_valid_indicator,
  output logic                                 echo_clock_true,
  output logic                                 echo_clock_complement,
  input  wire logic                            dll_on,
  input  wire logic [ddrbs_pkg::IMP_W-1:0]     impedance_target,
  output logic [ddrbs_pkg::IMP_W-1:0]          imp_code,
  output logic                                 cal_done,
  output logic                                 dev_ready,
  input  wire logic                            input_termination_ctrl,
  input  wire logic                            term_option,
  output logic                                 term_clk_en,
  output logic [1:0]                           term_data_en,
  output logic                                 term_bw_en
);
  localparam int LW    = ddrbs_pkg::LANE_W;
  localparam int BYTES = DATA_W / LW;
  localparam int DEPTH = 1 << (ADDR_W + 1);

  // ----------------------------------------
  // Link-domain state
  // ----------------------------------------
  typedef struct packed {
    logic                               rst_s1, rst_s2;
    logic                               rdy_s1, rdy_s2;
    logic                               byp_s1, byp_s2;
    logic                               wr_pend;
    logic [ADDR_W-1:0]                  wr_addr;
    logic [1:0]                         bv;
    logic [1:0][ADDR_W-1:0]             baddr;
    logic [1:0][1:0][DATA_W-1:0]        bdata;
    logic [1:0][1:0][BYTES-1:0]         bmask;
    logic                               rd1;
    logic [ADDR_W-1:0]                  rd1_addr;
    logic                               rd2;
    logic [1:0][DATA_W-1:0]             rd2_d;
    logic                               q_v;
    logic [1:0][DATA_W-1:0]             q_d;
    logic [1:0]                         ind;
    logic [1:0]                         toff;
  } ddrbs_lnk_t;

  ddrbs_lnk_t              r, n;
  logic [DATA_W-1:0]       mem [0:DEPTH-1];
  logic [1:0][DATA_W-1:0]  look;
  logic [1:0][DATA_W-1:0]  din;
  logic [1:0][BYTES-1:0]   bwn;
  logic                    sys_ready;
  logic                    sys_byp;
  logic                    link_rst;
  logic                    rd_cmd;
  logic                    wr_cmd;
  logic                    mem_we;
  logic                    ahead;

  // Linear one-bit burst counter: start address, then start plus one
  function automatic logic [ADDR_W:0] beat_idx(input logic [ADDR_W-1:0] a,
                                               input logic b);
    beat_idx = {a, 1'b0} + {{ADDR_W{1'b0}}, b};
  endfunction : beat_idx

  function automatic logic [DATA_W-1:0] lane_mix(input logic [DATA_W-1:0] base,
                                                 input logic [DATA_W-1:0] d,
                                                 input logic [BYTES-1:0]  en);
    lane_mix = base;
    for (int i = 0; i < BYTES; i++) begin
      if (en[i]) begin
        lane_mix[i*LW +: LW] = d[i*LW +: LW];
      end
    end
  endfunction : lane_mix

  // ----------------------------------------
  // System-clock side
  // ----------------------------------------
  // The raw link clock is sampled as data here to spot a stopped clock and to count lock edges
  ddrbs_pwr #(
    .STOP_CYC   (STOP_CYC)
  ) u_pwr (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .k_level    (clk_link),
    .dll_on     (dll_on),
    .imp_target (impedance_target),
    .dev_ready  (sys_ready),
    .dll_bypass (sys_byp),
    .cal_done   (cal_done),
    .imp_code   (imp_code)
  );
  assign dev_ready = sys_ready;

  // ----------------------------------------
  // Command decode and read lookup
  // ----------------------------------------
  assign link_rst = r.rst_s2;
  assign din      = {dq_in_b1, dq_in_b0};
  assign bwn      = {byte_write_strobe_n_b1, byte_write_strobe_n_b0};
  // Commands before ready are dropped: the array is not usable yet
  assign rd_cmd   = r.rdy_s2 & ~load_address_n & rw_sel;
  assign wr_cmd   = r.rdy_s2 & ~load_address_n & ~rw_sel;
  assign mem_we   = ~link_rst & r.wr_pend & r.bv[1];

  // Oldest first so the newest bytes win
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      look[b] = mem[beat_idx(r.rd1_addr, b[0])];
      for (int e = 1; e >= 0; e--) begin
        if (r.bv[e] && r.baddr[e] == r.rd1_addr) begin
          look[b] = lane_mix(look[b], r.bdata[e][b], r.bmask[e][b]);
        end
      end
      if (r.wr_pend && r.wr_addr == r.rd1_addr) begin
        look[b] = lane_mix(look[b], din[b], ~bwn[b]);
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n         = r;
    n.wr_pend = wr_cmd;
    n.wr_addr = addr;
    n.rd1     = rd_cmd;
    n.rd1_addr = addr;
    // Late write: data beats land one cycle after the command
    if (r.wr_pend) begin
      n.bv       = {r.bv[0], 1'b1};
      n.baddr[1] = r.baddr[0];
      n.bdata[1] = r.bdata[0];
      n.bmask[1] = r.bmask[0];
      n.baddr[0] = r.wr_addr;
      n.bdata[0] = din;
      n.bmask[0] = ~bwn;
    end
    n.rd2   = r.rd1 & ~r.byp_s2;
    n.rd2_d = look;
    if (r.byp_s2) begin
      n.q_v = r.rd1;
      n.q_d = look;
      ahead = rd_cmd;
    end else begin
      n.q_v = r.rd2;
      n.q_d = r.rd2_d;
      ahead = n.rd2;
    end
    // Half-cycle slots: indicator and termination run one slot ahead
    n.ind  = {ahead, n.q_v};
    n.toff = {n.q_v | ahead, n.q_v | r.q_v};
    if (link_rst) begin
      n = '0;
    end
    n.rst_s1 = sys_rst;
    n.rst_s2 = r.rst_s1;
    n.rdy_s1 = sys_ready;
    n.rdy_s2 = r.rdy_s1;
    n.byp_s1 = sys_byp;
    n.byp_s2 = r.byp_s1;
  end

  always_ff @(posedge clk_link) begin
    r <= n;
  end

  // Only enabled lanes of the oldest buffered write reach the array
  always_ff @(posedge clk_link) begin
    if (mem_we) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < BYTES; i++) begin
          if (r.bmask[1][b][i]) begin
            mem[beat_idx(r.baddr[1], b[0])][i*LW +: LW] <= r.bdata[1][b][i*LW +: LW];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign dq_out_b0             = r.q_d[0];
  assign dq_out_b1             = r.q_d[1];
  assign dq_oe_n               = ~r.q_v;
  assign read_valid_indicator  = r.ind;
  // Echo clocks follow the input pair; fine delay is outside this model
  assign echo_clock_true       = clk_link;
  assign echo_clock_complement = ~clk_link;
  assign term_clk_en  = input_termination_ctrl & ~term_option;
  assign term_bw_en   = input_termination_ctrl;
  assign term_data_en = {2{input_termination_ctrl}} & ~r.toff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking lcb @(posedge clk_link); endclocking
  default disable iff (link_rst);

  sequence s_rd_dll;
    rd_cmd && !r.byp_s2 ##1 !r.byp_s2 ##1 !r.byp_s2;
  endsequence
  sequence s_rd_byp;
    rd_cmd && r.byp_s2 ##1 r.byp_s2;
  endsequence

  a_select_no_write: assert property ((!load_address_n && rw_sel) |=>
    !r.wr_pend) else $error("write started with select high");
  a_commit_third: assert property (r.wr_pend |-> (mem_we == r.bv[1]))
    else $error("array write not on the third write");
  // The output registers load on the edge that ends each sequence, so look one edge later
  a_read_lat_two: assert property (s_rd_dll |=> !dq_oe_n)
    else $error("read data missing at latency two");
  a_read_lat_one: assert property (s_rd_byp |=> !dq_oe_n)
    else $error("bypass read data missing at latency one");
  a_term_off_data: assert property (!dq_oe_n |-> r.toff == 2'b11)
    else $error("termination on while driving");
  a_term_tail: assert property (($past(!dq_oe_n) && dq_oe_n) |-> r.toff[0])
    else $error("termination back on too early");
  a_valid_lead: assert property (r.ind[1] |=> !dq_oe_n)
    else $error("valid indicator not followed by data");
  a_buf_coherent: assert property ((r.rd1 && r.bv[0] && r.baddr[0] == r.rd1_addr
    && &r.bmask[0][0] && !(r.wr_pend && r.wr_addr == r.rd1_addr))
    |-> look[0] == r.bdata[0][0]) else $error("read missed buffered data");

  // ----------------------------------------
  // Write path, read burst counter and termination checks
  // ----------------------------------------
  // Buffers shift only when late write data arrives; nothing else may touch the array
  sequence s_wr_data;
    wr_cmd ##1 r.wr_pend;
  endsequence

  sequence s_rd_miss;
    r.rd1 && !(r.bv[0] && r.baddr[0] == r.rd1_addr)
      && !(r.bv[1] && r.baddr[1] == r.rd1_addr);
  endsequence

  a_idle_no_store: assert property (!r.wr_pend |-> !mem_we)
    else $error("array written without write data");
  a_buffer_fill: assert property (s_wr_data |=>
    r.bv[0] && r.baddr[0] == $past(r.wr_addr))
    else $error("write data not held in the buffer");
  a_mask_taken: assert property (r.wr_pend |=> r.bmask[0] == ~$past(bwn))
    else $error("byte strobes not kept per beat");
  // A miss reads the array directly, which exposes the burst counter
  a_second_beat: assert property (s_rd_miss |->
    look[1] == mem[beat_idx(r.rd1_addr, 1'b1)])
    else $error("second beat address wrong");
  a_clk_term_opt: assert property (term_option |-> !term_clk_en)
    else $error("clock termination on in option two");
  // Outside the read window the data lanes follow the termination input
  a_data_term_wr: assert property ((dq_oe_n && r.toff == 2'b00) |->
    term_data_en == {2{input_termination_ctrl}})
    else $error("termination off outside reads");
endmodule : ddrbs_core

// [src/ddrbs_pkg.sv]
// Shared constants for the burst-of-two SRAM core
package ddrbs_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLK_STOP_NS   = 30;
  localparam int CLK_STOP_CYC  = (CLK_STOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_CYC      = 2048;
  localparam int CAL_CYC       = 1024;
  localparam int IMP_W         = 4;
  localparam int IMP_STEPS     = 16;
  localparam int CAL_STEP_CYC  = CAL_CYC / IMP_STEPS;
  localparam logic [IMP_W-1:0] IMP_MID = 4'h8;
  // ----------------------------------------
  // Data organisation
  // ----------------------------------------
  localparam int LANE_W   = 9;
  localparam int DATA_W   = 36;
  localparam int ADDR_W   = 18;
  localparam int BURST_LEN = 2;
  localparam int RL_DLL   = 2;
  localparam int RL_BYP   = 1;
  // ----------------------------------------
  // Power-up sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {
    PW_RESET   = 2'b00,
    PW_LOCKING = 2'b01,
    PW_READY   = 2'b10
  } ddrbs_pwr_t;
endpackage : ddrbs_pkg

// [src/ddrbs_pwr.sv]
// Loop lock, clock-stop detection and impedance calibration on the system clock
`timescale 1ns/1ps
module ddrbs_pwr #(
  parameter int STOP_CYC = ddrbs_pkg::CLK_STOP_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        k_level,
  input  wire logic                        dll_on,
  input  wire logic [ddrbs_pkg::IMP_W-1:0] imp_target,
  output logic                             dev_ready,
  output logic                             dll_bypass,
  output logic                             cal_done,
  output logic [ddrbs_pkg::IMP_W-1:0]      imp_code
);
  typedef struct packed {
    logic                        k_s1, k_s2, k_d;
    logic                        on_s1, on_s2, on_d;
    logic [ddrbs_pkg::IMP_W-1:0] tgt_s1, tgt_s2;
    logic [7:0]                  stop_cnt;
    logic [11:0]                 lock_cnt;
    ddrbs_pkg::ddrbs_pwr_t       state;
    logic [10:0]                 cal_cnt;
    logic [6:0]                  step_cnt;
    logic [ddrbs_pkg::IMP_W-1:0] imp;
    logic                        cal_done;
  } ddrbs_pst_t;

  ddrbs_pst_t r, n;
  logic       k_edge;
  logic       dll_rst;

  always_comb begin
    n        = r;
    k_edge   = r.k_s2 & ~r.k_d;
    // A stopped clock pair or a rising loop-enable restarts locking
    dll_rst  = (r.on_s2 & ~r.on_d) | (r.stop_cnt == 8'(STOP_CYC));
    n.k_s1   = k_level;
    n.k_s2   = r.k_s1;
    n.k_d    = r.k_s2;
    n.on_s1  = dll_on;
    n.on_s2  = r.on_s1;
    n.on_d   = r.on_s2;
    n.tgt_s1 = imp_target;
    n.tgt_s2 = r.tgt_s1;
    if (r.k_s2 != r.k_d) begin
      n.stop_cnt = 8'h00;
    end else if (r.stop_cnt != 8'(STOP_CYC)) begin
      n.stop_cnt = r.stop_cnt + 8'h01;
    end
    case (r.state)
      ddrbs_pkg::PW_RESET: begin
        n.state    = ddrbs_pkg::PW_LOCKING;
        n.lock_cnt = 12'h000;
      end
      ddrbs_pkg::PW_LOCKING: begin
        if (!r.on_s2) begin
          n.state = ddrbs_pkg::PW_READY;
        end else if (k_edge) begin
          if (r.lock_cnt == 12'(ddrbs_pkg::LOCK_CYC - 1)) begin
            n.state = ddrbs_pkg::PW_READY;
          end else begin
            n.lock_cnt = r.lock_cnt + 12'h001;
          end
        end
      end
      ddrbs_pkg::PW_READY: begin
      end
      default: n.state = ddrbs_pkg::PW_RESET;
    endcase
    if (dll_rst && r.on_s2) begin
      n.state    = ddrbs_pkg::PW_LOCKING;
      n.lock_cnt = 12'h000;
    end
    // Periodic drift tracking, one code step per interval
    if (r.cal_cnt != 11'(ddrbs_pkg::CAL_CYC)) begin
      n.cal_cnt = r.cal_cnt + 11'h001;
    end
    n.cal_done = (r.cal_cnt == 11'(ddrbs_pkg::CAL_CYC));
    if (r.step_cnt == 7'(ddrbs_pkg::CAL_STEP_CYC - 1)) begin
      n.step_cnt = 7'h00;
      if (r.imp < r.tgt_s2) begin
        n.imp = r.imp + 4'h1;
      end else if (r.imp > r.tgt_s2) begin
        n.imp = r.imp - 4'h1;
      end
    end else begin
      n.step_cnt = r.step_cnt + 7'h01;
    end
    if (sys_rst) begin
      n     = '0;
      n.imp = ddrbs_pkg::IMP_MID;
    end
  end

  always_ff @(posedge clk_sys) begin
    r <= n;
  end

  assign dev_ready  = (r.state == ddrbs_pkg::PW_READY);
  assign dll_bypass = ~r.on_s2;
  assign cal_done   = r.cal_done;
  assign imp_code   = r.imp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_loop_rise_reset: assert property ((r.on_s2 && !r.on_d) |=>
    (r.state == ddrbs_pkg::PW_LOCKING && r.lock_cnt == 12'h000))
    else $error("loop enable rise did not restart locking");
  a_lock_after_count: assert property (($rose(dev_ready) && $past(r.on_s2)) |->
    $past(r.lock_cnt) == 12'(ddrbs_pkg::LOCK_CYC - 1))
    else $error("ready before the full lock count");
  a_bypass_skip_lock: assert property ((!r.on_s2 && r.state == ddrbs_pkg::PW_LOCKING)
    |=> dev_ready) else $error("bypass did not skip locking");
  a_imp_slow_step: assert property ($changed(r.imp) |->
    $past(r.step_cnt) == 7'(ddrbs_pkg::CAL_STEP_CYC - 1))
    else $error("impedance code moved off its interval");
endmodule : ddrbs_pwr
